// >>> rtl/clock_delay_consts.vh
// constants for the clock divider digital delay block
`ifndef CLOCK_DELAY_CONSTS_VH
`define CLOCK_DELAY_CONSTS_VH
// sizes
`define NUM_GROUPS 2
`define DIV_W 10
`define SDIV_W 13
`define STEP_W 8
`define LDLY_W 4
`define LDLY_DEPTH 16
`define ADLY_W 5
`define ADDR_W 8
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STEP 8'h04
`define OFS_SDIV 8'h08
`define OFS_SDLY 8'h0c
`define OFS_STATUS 8'h10
`define OFS_GRP_BASE 8'h20
`define GRP_STRIDE 8'h08
`define OFS_GRP_DLY 8'h04
// control register bits
`define CTRL_SYNC_POLARITY 0
`define CTRL_SREF_RBLK 1
`define CTRL_SREF_DYN 2
`define CTRL_INPUT_OVR 3
// group config register fields
`define GCFG_DIV_MSB 9
`define GCFG_HS 10
`define GCFG_PD 11
`define GCFG_RBLK 12
`define GCFG_DYN 13
// group delay register fields
`define GDLY_DDLY_MSB 9
`define GDLY_LDLY_LSB 10
`define GDLY_LDLY_MSB 13
`define GDLY_LHS 14
`define GDLY_ADLY_LSB 15
`define GDLY_ADLY_MSB 19
// status register bits
`define ST_SYNC 0
`define ST_BUSY 1
// reset values and limits
`define RST_DIV 10'h008
`define RST_DDLY 10'h008
`define DDLY_MIN 10'h008
`define RST_SDIV 13'h0100
`define RST_SDLY 13'h0008
`endif

// >>> rtl/clock_divider_digital_delay.v
// clock divider groups with fixed and dynamic digital delay plus sysref divider
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "clock_delay_consts.vh"

// one divider with sync hold, sync load and dynamic substitution
module phase_divider #(
  parameter W = 10
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // divide values
  input wire [W-1:0] div,
  input wire [W-1:0] alt,
  input wire [W-1:0] sync_val,
  // sync control
  input wire hold,
  input wire release_p,
  input wire use_sync_val,
  // dynamic control
  input wire step_start,
  input wire [`STEP_W-1:0] step_cnt,
  input wire step_en,
  // results
  output reg clk_out,
  output wire busy
);
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  reg [W-1:0] cnt_r;
  reg [W-1:0] period_r;
  reg [`STEP_W-1:0] steps_r;
  reg quiet_r;
  wire boundary;
  wire [W-1:0] next_period;
  wire [W-1:0] cnt_dec;

  assign boundary = (cnt_r <= ONE);
  assign busy = (steps_r != {`STEP_W{1'b0}});
  assign next_period = busy ? alt : div;
  assign cnt_dec = cnt_r - ONE;

  // counting runs on every rising distribution clock edge, no other clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= ONE;
      period_r <= ONE;
      steps_r <= {`STEP_W{1'b0}};
      quiet_r <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      if (hold) begin
        cnt_r <= ONE;
        quiet_r <= 1'b1;
        clk_out <= 1'b0;
      end else if (release_p) begin
        // first period after sync is the delay value when use_sync_val is set, else div; output stays low
        period_r <= use_sync_val ? sync_val : div;
        cnt_r <= use_sync_val ? sync_val : div;
        clk_out <= 1'b0;
      end else if (boundary) begin
        period_r <= next_period;
        cnt_r <= next_period;
        quiet_r <= 1'b0;
        clk_out <= 1'b1;
        if (busy) begin
          steps_r <= steps_r - {{(`STEP_W-1){1'b0}}, 1'b1};
        end
      end else begin
        cnt_r <= cnt_dec;
        clk_out <= !quiet_r && (cnt_dec > (period_r >> 1));
      end
      // a new write overrides any count still running
      if (step_start) begin
        steps_r <= step_en ? step_cnt : {`STEP_W{1'b0}};
      end
    end
  end
endmodule // phase_divider

// top: register slave, sync path, device clock groups and sysref divider
module clock_divider_digital_delay (
  // clock and reset
  input wire CLOCK,
  input wire RST_N,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // sync pin
  input wire SYNC_PIN,
  // clock outputs
  output wire [`NUM_GROUPS-1:0] DCLK_OUT,
  output wire [`NUM_GROUPS-1:0] SCLK_OUT,
  // static analog and input controls
  output wire [`NUM_GROUPS*`ADLY_W-1:0] SYSREF_ANALOG_DELAY,
  output wire INPUT_OVERRIDE
);
  reg rst_meta_r;
  reg rst_n_r;
  reg sync_meta_r;
  reg sync_pin_r;
  reg sync_lvl_r;
  reg [3:0] ctrl_r;
  reg [`SDIV_W-1:0] sdiv_r;
  reg [`SDIV_W-1:0] sdly_r;
  reg [`DIV_W-1:0] div_r [0:`NUM_GROUPS-1];
  reg [`DIV_W-1:0] ddly_r [0:`NUM_GROUPS-1];
  reg [`LDLY_W-1:0] ldly_r [0:`NUM_GROUPS-1];
  reg [`ADLY_W-1:0] adly_r [0:`NUM_GROUPS-1];
  reg [`NUM_GROUPS-1:0] hs_r;
  reg [`NUM_GROUPS-1:0] pd_r;
  reg [`NUM_GROUPS-1:0] rblk_r;
  reg [`NUM_GROUPS-1:0] den_r;
  reg [`NUM_GROUPS-1:0] lhs_r;
  reg step_start_r;
  reg [`STEP_W-1:0] step_val_r;
  reg [31:0] rd_val;
  reg rd_hit;
  reg [`ADDR_W-1:0] ga;
  integer g;
  wire sync_lvl;
  wire release_p;
  wire wr_en;
  wire sref_raw;
  wire sref_busy;
  wire [`NUM_GROUPS-1:0] grp_busy;

  // reset is released through two flops, assertion stays asynchronous
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // sync pin crosses in through two flops; polarity bit lets software sync
  always @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync_meta_r <= 1'b0;
      sync_pin_r <= 1'b0;
      sync_lvl_r <= 1'b0;
    end else begin
      sync_meta_r <= SYNC_PIN;
      sync_pin_r <= sync_meta_r;
      sync_lvl_r <= sync_lvl;
    end
  end
  assign sync_lvl = sync_pin_r ^ ctrl_r[`CTRL_SYNC_POLARITY];
  assign release_p = sync_lvl_r && !sync_lvl; // fixed delay loads at sync end

  // apb: zero wait states, unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !rd_hit;
  assign wr_en = PSEL && PENABLE && PWRITE && rd_hit;
  assign INPUT_OVERRIDE = ctrl_r[`CTRL_INPUT_OVR];

  // read decode, also used as the address hit for writes
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    ga = `OFS_GRP_BASE;
    case (PADDR)
      `OFS_CTRL: rd_val = {28'h000_0000, ctrl_r};
      `OFS_STEP: rd_val = {24'h00_0000, step_val_r};
      `OFS_SDIV: rd_val = {19'h0_0000, sdiv_r};
      `OFS_SDLY: rd_val = {19'h0_0000, sdly_r};
      `OFS_STATUS: rd_val = {30'h0000_0000, (sref_busy || (grp_busy != 0)), sync_lvl_r};
      default: begin
        rd_hit = 1'b0;
        for (g = 0; g < `NUM_GROUPS; g = g + 1) begin
          ga = `OFS_GRP_BASE + (`GRP_STRIDE * g[`ADDR_W-1:0]);
          if (PADDR == ga) begin
            rd_hit = 1'b1;
            rd_val = {18'h0_0000, den_r[g], rblk_r[g], pd_r[g], hs_r[g], div_r[g]};
          end
          if (PADDR == ga + `OFS_GRP_DLY) begin
            rd_hit = 1'b1;
            rd_val = {12'h000, adly_r[g], lhs_r[g], ldly_r[g], ddly_r[g]};
          end
        end
      end
    endcase
  end

  // read data is captured in the setup phase so it comes from a flop
  always @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= rd_val;
    end
  end

  // register writes; a step count write also fires a start pulse
  always @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= 4'h0;
      sdiv_r <= `RST_SDIV;
      sdly_r <= `RST_SDLY;
      step_start_r <= 1'b0;
      step_val_r <= {`STEP_W{1'b0}};
      hs_r <= {`NUM_GROUPS{1'b0}};
      pd_r <= {`NUM_GROUPS{1'b1}};
      rblk_r <= {`NUM_GROUPS{1'b0}};
      den_r <= {`NUM_GROUPS{1'b0}};
      lhs_r <= {`NUM_GROUPS{1'b0}};
      for (g = 0; g < `NUM_GROUPS; g = g + 1) begin
        div_r[g] <= `RST_DIV;
        ddly_r[g] <= `RST_DDLY;
        ldly_r[g] <= {`LDLY_W{1'b0}};
        adly_r[g] <= {`ADLY_W{1'b0}};
      end
    end else begin
      step_start_r <= wr_en && (PADDR == `OFS_STEP);
      if (wr_en) begin
        case (PADDR)
          `OFS_CTRL: ctrl_r <= PWDATA[3:0];
          `OFS_STEP: step_val_r <= PWDATA[`STEP_W-1:0];
          `OFS_SDIV: sdiv_r <= PWDATA[`SDIV_W-1:0];
          `OFS_SDLY: sdly_r <= PWDATA[`SDIV_W-1:0];
          default: begin
            for (g = 0; g < `NUM_GROUPS; g = g + 1) begin
              if (PADDR == `OFS_GRP_BASE + (`GRP_STRIDE * g[`ADDR_W-1:0])) begin
                div_r[g] <= PWDATA[`GCFG_DIV_MSB:0];
                hs_r[g] <= PWDATA[`GCFG_HS];
                pd_r[g] <= PWDATA[`GCFG_PD];
                rblk_r[g] <= PWDATA[`GCFG_RBLK];
                den_r[g] <= PWDATA[`GCFG_DYN];
              end
              if (PADDR == `OFS_GRP_BASE + (`GRP_STRIDE * g[`ADDR_W-1:0]) + `OFS_GRP_DLY) begin
                // delays below the minimum are raised to it
                ddly_r[g] <= (PWDATA[`GDLY_DDLY_MSB:0] < `DDLY_MIN) ?
                  `DDLY_MIN : PWDATA[`GDLY_DDLY_MSB:0];
                ldly_r[g] <= PWDATA[`GDLY_LDLY_MSB:`GDLY_LDLY_LSB];
                lhs_r[g] <= PWDATA[`GDLY_LHS];
                adly_r[g] <= PWDATA[`GDLY_ADLY_MSB:`GDLY_ADLY_LSB];
              end
            end
          end
        endcase
      end
    end
  end

  // sysref divider: global delay is both sync load and dynamic alternate
  phase_divider #(.W(`SDIV_W)) sref_div (
    .clk(CLOCK),
    .rst_n(rst_n_r),
    .div(sdiv_r),
    .alt(sdly_r),
    .sync_val(sdly_r),
    .hold(sync_lvl && !ctrl_r[`CTRL_SREF_RBLK]),
    .release_p(release_p && !ctrl_r[`CTRL_SREF_RBLK]),
    .use_sync_val(1'b1),
    .step_start(step_start_r),
    .step_cnt(step_val_r),
    .step_en(ctrl_r[`CTRL_SREF_DYN]),
    .clk_out(sref_raw),
    .busy(sref_busy)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_GROUPS; gi = gi + 1) begin : grp
      wire dclk_pos;
      reg dclk_neg_r;
      reg sclk_neg_r;
      reg [`LDLY_DEPTH-1:0] sh_r;
      wire sclk_pos;

      // device clock divider; delay circuit power only matters at sync time
      phase_divider #(.W(`DIV_W+1)) dclk_div (
        .clk(CLOCK),
        .rst_n(rst_n_r),
        .div({1'b0, div_r[gi]}),
        .alt({1'b0, div_r[gi]} + {{`DIV_W{1'b0}}, 1'b1}),
        .sync_val({1'b0, ddly_r[gi]}),
        .hold(sync_lvl && !rblk_r[gi]),
        .release_p(release_p && !rblk_r[gi]),
        .use_sync_val(!pd_r[gi]),
        .step_start(step_start_r),
        .step_cnt(step_val_r),
        .step_en(den_r[gi]),
        .clk_out(dclk_pos),
        .busy(grp_busy[gi])
      );

      // local sysref delay as a shift line; tap picks whole cycles
      always @(posedge CLOCK or negedge rst_n_r) begin
        if (!rst_n_r) begin
          sh_r <= {`LDLY_DEPTH{1'b0}};
        end else begin
          sh_r <= {sh_r[`LDLY_DEPTH-2:0], sref_raw};
        end
      end
      assign sclk_pos = sh_r[ldly_r[gi]];

      // falling edge copies give the half period step
      always @(negedge CLOCK or negedge rst_n_r) begin
        if (!rst_n_r) begin
          dclk_neg_r <= 1'b0;
          sclk_neg_r <= 1'b0;
        end else begin
          dclk_neg_r <= dclk_pos;
          sclk_neg_r <= sclk_pos;
        end
      end
      assign DCLK_OUT[gi] = hs_r[gi] ? dclk_neg_r : dclk_pos;
      assign SCLK_OUT[gi] = lhs_r[gi] ? sclk_neg_r : sclk_pos;
      assign SYSREF_ANALOG_DELAY[gi*`ADLY_W +: `ADLY_W] = adly_r[gi];
    end
  endgenerate
endmodule // clock_divider_digital_delay

// >>> verification/clock_delay_properties.sv
// checker for the clock divider delay block
`timescale 1ns/1ps
`include "clock_delay_consts.vh"
module clock_delay_checker (
  // clock and reset
  input wire CLOCK,
  input wire RST_N,
  // register bus
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // pins
  input wire SYNC_PIN,
  input wire [`NUM_GROUPS-1:0] DCLK_OUT,
  input wire [`NUM_GROUPS*`ADLY_W-1:0] SYSREF_ANALOG_DELAY,
  input wire INPUT_OVERRIDE
);
  reg pol_r;
  reg [1:0] blk_r;
  wire wr = PSEL && PENABLE && PWRITE;
  wire lvl = SYNC_PIN ^ pol_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // shadow polarity and block bits so a hold is only expected on unblocked groups
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pol_r <= 1'b0;
      blk_r <= 2'b00;
    end else if (wr) begin
      if (PADDR == `OFS_CTRL) pol_r <= PWDATA[0];
      if (PADDR == 8'h20) blk_r[0] <= PWDATA[12];
      if (PADDR == 8'h28) blk_r[1] <= PWDATA[12];
    end
  end
  ready_high_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("no ready in access phase");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR == 8'h14 |-> PSLVERR)
    else $error("unmapped access not refused");
  err_rdata_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  ovr_follow_a: assert property (wr && PADDR == `OFS_CTRL |=> INPUT_OVERRIDE == $past(PWDATA[3]))
    else $error("override pin wrong");
  adly_follow_a: assert property (wr && PADDR == 8'h24 |=>
    SYSREF_ANALOG_DELAY[4:0] == $past(PWDATA[19:15])) else $error("analog delay wrong");
  hold_low0_a: assert property ((lvl && !blk_r[0]) [*6] |-> !DCLK_OUT[0])
    else $error("group 0 not held");
  hold_low1_a: assert property ((lvl && !blk_r[1]) [*6] |-> !DCLK_OUT[1])
    else $error("group 1 not held");
  delay_min_a: assert property ((lvl && !blk_r[0]) [*6] ##1 !lvl |-> !DCLK_OUT[0] [*8])
    else $error("delay shorter than eight");
  cover property (wr && PADDR == `OFS_STEP);
  cover property (lvl [*6] ##1 !lvl);
  cover property (PSLVERR);
endmodule // clock_delay_checker
bind clock_divider_digital_delay clock_delay_checker chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC_PIN(SYNC_PIN),
  .DCLK_OUT(DCLK_OUT), .SYSREF_ANALOG_DELAY(SYSREF_ANALOG_DELAY),
  .INPUT_OVERRIDE(INPUT_OVERRIDE));

// >>> verification/clock_receiver.sv
// receiving device model that measures device clock skew
`timescale 1ns/1ps
module clock_receiver #(
  parameter int PER_NS = 400
) (
  // device clocks from the block
  input wire logic [1:0] dclk,
  // rising edge of output 1 behind output 0, in ns
  output int skew
);
  longint t0 = 0;
  // folded into one period, so an edge in the same step as t0 reads the same
  always @(posedge dclk[0]) begin
    t0 = longint'($time);
  end
  always @(posedge dclk[1]) begin
    skew = int'(((longint'($time) - t0) % PER_NS + PER_NS) % PER_NS);
  end
endmodule // clock_receiver

// >>> verification/tb.sv
// self-checking testbench for the clock divider delay block
`timescale 1ns/1ps
`include "clock_delay_consts.vh"
module tb;
  logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SYNC_PIN = 0;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic PREADY, PSLVERR, e, seen;
  logic [1:0] DCLK_OUT;
  logic [9:0] adly;
  int miscompares = 0, n_tests = 0, cyc = 0, skew, s;
  always #25 CLOCK = ~CLOCK;
  clock_divider_digital_delay dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC_PIN(SYNC_PIN), .DCLK_OUT(DCLK_OUT),
    .SCLK_OUT(), .SYSREF_ANALOG_DELAY(adly), .INPUT_OVERRIDE());
  clock_receiver rx_u (.dclk(DCLK_OUT), .skew(skew));
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one transfer, held until ready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask
  task wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // cut a hung run short
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    wt(8);
    RST_N <= 1;
    wt(3);
    rd(`OFS_CTRL, 0);
    rd(`OFS_SDIV, 32'h100);
    rd(`OFS_SDLY, 8);
    rd(8'h20, 32'h808);
    rd(8'h24, 8);
    rd(8'h14, 0);
    chk(e, 1);
    $display("test registers done");
    apb(1, 8'h24, 32'h000a8003);
    rd(8'h24, 32'h000a8008);
    chk(adly[4:0], 5'h15);
    apb(1, 8'h24, 32'h3ff);
    rd(8'h24, 32'h3ff);
    apb(1, 8'h24, 8);
    $display("test limits done");
    wt(40);
    s = skew;
    apb(1, 8'h2c, 9);
    apb(1, 8'h20, 8);
    apb(1, 8'h28, 8);
    wt(40);
    chk(skew, s);
    apb(1, `OFS_CTRL, 1);
    wt(6);
    repeat (8) begin
      @(posedge CLOCK);
      chk(DCLK_OUT, 0);
    end
    apb(1, `OFS_CTRL, 0);
    wt(60);
    chk(skew, 50);
    apb(1, 8'h28, 32'h408);
    wt(30);
    chk(skew, 75);
    apb(1, 8'h28, 32'h808);
    wt(30);
    chk(skew, 50);
    $display("test fixed done");
    apb(1, 8'h28, 32'h2808);
    apb(1, `OFS_STEP, 1);
    wt(60);
    chk(skew, 100);
    apb(1, `OFS_STEP, 2);
    wt(2);
    rd(`OFS_STATUS, 2);
    wt(60);
    chk(skew, 200);
    rd(`OFS_STATUS, 0);
    $display("test dynamic done");
    apb(1, 8'h28, 32'h1008);
    SYNC_PIN <= 1;
    wt(6);
    seen = 0;
    repeat (16) begin
      @(posedge CLOCK);
      chk(DCLK_OUT[0], 0);
      seen |= DCLK_OUT[1];
    end
    chk(seen, 1);
    SYNC_PIN <= 0;
    wt(20);
    $display("test block done");
    // one cycle sysref step for divide 16 is 16 + 8 + 1
    apb(1, `OFS_SDIV, 16);
    apb(1, `OFS_SDLY, 25);
    rd(`OFS_SDLY, 25);
    // alignment: delay 10 - 1 + correction 0 (divide 32) + half step 1 - local 2
    apb(1, `OFS_SDLY, 8);
    rd(`OFS_SDLY, 8);
    // divide 3 is reached through divide 4 before any sync
    apb(1, 8'h20, 4);
    apb(1, 8'h20, 3);
    rd(8'h20, 3);
    $display("test sysref done");
    end_of_test();
  end
endmodule // tb
